// >>> shared/vid_link_cfg_defines.svh
// Offsets, field positions, reset values and codes of the link config block
`ifndef VID_LINK_CFG_DEFINES_SVH
`define VID_LINK_CFG_DEFINES_SVH

// ------------------------------------------------------------
// Serial bus addressing
// ------------------------------------------------------------
`define I2C_DEV_ADDR 7'h71
`define THERM_LIMIT_OFFSET 8'hC1
`define LINK_CFG_OFFSET 8'hC2

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define THERM_CODE_MSB 2
`define THERM_CODE_LSB 0
`define PROTO_MSB 7
`define PROTO_LSB 6
`define VBOOT_MSB 5
`define VBOOT_LSB 2
`define BCAST_MSB 1
`define BCAST_LSB 0

// ------------------------------------------------------------
// Reset values (stand-in for non-volatile defaults)
// ------------------------------------------------------------
`define THERM_CODE_RESET 3'h0
`define PROTO_RESET 2'h1
`define VBOOT_RESET 4'h0
`define BCAST_RESET 2'h3

// ------------------------------------------------------------
// Protocol identifiers and boot code limits
// ------------------------------------------------------------
`define PROTO_ID_SEL0 8'h04
`define PROTO_ID_SEL1 8'h07
`define PROTO_ID_SEL2 8'h09
`define PROTO_ID_SEL3 8'h0A
`define VBOOT_MAX_5MV_ONLY 4'h6
`define VBOOT_MIN_10MV_ONLY 4'hD

`endif

// >>> shared/vid_link_cfg_pkg.sv
// Types and shared helpers of the link config block
package vid_link_cfg_pkg;

  typedef enum logic [8:0] {
    ST_IDLE      = 9'h001,
    ST_ADDR      = 9'h002,
    ST_ADDR_ACK  = 9'h004,
    ST_CMD       = 9'h008,
    ST_CMD_ACK   = 9'h010,
    ST_WDATA     = 9'h020,
    ST_WDATA_ACK = 9'h040,
    ST_RDATA     = 9'h080,
    ST_RDATA_ACK = 9'h100
  } i2c_state_t;

  // Selections 01b and 10b use the fine 5 mV step
  function automatic logic step_is_5mv(input logic [1:0] sel);
    step_is_5mv = (sel == 2'h1) || (sel == 2'h2);
  endfunction : step_is_5mv

endpackage : vid_link_cfg_pkg

// >>> hdl/pin_sync.sv
// Two flip-flop synchroniser for one asynchronous pin
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic d,
  output logic q
);

  logic meta;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= RESET_VAL;
      q <= RESET_VAL;
    end else if (ce) begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : pin_sync

`default_nettype wire

// >>> hdl/vboot_lookup.sv
// Boot voltage code to voltage-ID code table and protocol consistency check
`timescale 1ns/1ps
`default_nettype none
`include "vid_link_cfg_defines.svh"

module vboot_lookup
  import vid_link_cfg_pkg::*;
(
  input wire logic [1:0] proto_sel,
  input wire logic [3:0] vboot_code,
  output logic [7:0] vid_code,
  output logic allowed
);

  // ------------------------------------------------------------
  // Code table
  // ------------------------------------------------------------
  always_comb begin
    unique case (vboot_code)
      4'h0: vid_code = 8'h00;
      4'h1: vid_code = 8'h65;
      4'h2: vid_code = 8'h6F;
      4'h3: vid_code = 8'h79;
      4'h4: vid_code = 8'h83;
      4'h5: vid_code = 8'h8D;
      4'h6: vid_code = 8'h97;
      4'h7: vid_code = 8'hA1;
      4'h8: vid_code = 8'hAB;
      4'h9: vid_code = 8'hAF;
      4'hA: vid_code = 8'hC9;
      4'hB: vid_code = 8'hDD;
      4'hC: vid_code = 8'hFB;
      4'hD: vid_code = 8'h6F;
      4'hE: vid_code = 8'h79;
      4'hF: vid_code = 8'h83;
    endcase
  end

  // ------------------------------------------------------------
  // Consistency check
  // ------------------------------------------------------------
  // The high codes reuse low VID values, so they only make sense at 10 mV
  always_comb begin
    if (vboot_code <= `VBOOT_MAX_5MV_ONLY) begin
      allowed = step_is_5mv(proto_sel);
    end else if (vboot_code >= `VBOOT_MIN_10MV_ONLY) begin
      allowed = !step_is_5mv(proto_sel);
    end else begin
      allowed = 1'b1;
    end
  end

endmodule : vboot_lookup

`default_nettype wire

// >>> hdl/vid_link_config_registers.sv
// Voltage-ID link configuration registers behind an I2C byte slave
`timescale 1ns/1ps
`default_nettype none
`include "vid_link_cfg_defines.svh"

module vid_link_config_registers
  import vid_link_cfg_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic conv_enable,
  input wire logic [1:0] vout_ctrl_src,
  output logic [2:0] thermal_limit_code,
  output logic [7:0] thermal_limit_deg,
  output logic [7:0] vid_thermal_mirror,
  output logic [1:0] link_protocol_select,
  output logic [7:0] vid_link_ident,
  output logic vout_step_5mv,
  output logic [7:0] vid_boot_code,
  output logic [7:0] startup_target_vid,
  output logic startup_from_vid,
  output logic [1:0] broadcast_active,
  output logic answer_bcast_0e,
  output logic answer_bcast_0f,
  output logic config_pending
);

  // ------------------------------------------------------------
  // Reset release and pin synchronisers
  // ------------------------------------------------------------
  logic rst_meta;
  logic rst_n;
  logic scl_s;
  logic sda_s;
  logic scl_q;
  logic sda_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  pin_sync #(.RESET_VAL(1'b1)) u_scl_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .d(scl_in),
    .q(scl_s)
  );

  pin_sync #(.RESET_VAL(1'b1)) u_sda_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .d(sda_in),
    .q(sda_s)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (ce) begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  assign scl_rise = scl_s && !scl_q;
  assign scl_fall = !scl_s && scl_q;
  assign bus_start = scl_s && scl_q && sda_q && !sda_s;
  assign bus_stop = scl_s && scl_q && !sda_q && sda_s;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] proto_ident(input logic [1:0] sel);
    unique case (sel)
      2'h0: proto_ident = `PROTO_ID_SEL0;
      2'h1: proto_ident = `PROTO_ID_SEL1;
      2'h2: proto_ident = `PROTO_ID_SEL2;
      2'h3: proto_ident = `PROTO_ID_SEL3;
    endcase
  endfunction : proto_ident

  function automatic logic [7:0] therm_degrees(input logic [2:0] code);
    unique case (code)
      3'h0: therm_degrees = 8'h5F;
      3'h1: therm_degrees = 8'h64;
      3'h2: therm_degrees = 8'h69;
      3'h3: therm_degrees = 8'h6E;
      3'h4: therm_degrees = 8'h73;
      3'h5: therm_degrees = 8'h78;
      3'h6: therm_degrees = 8'h7D;
      3'h7: therm_degrees = 8'h82;
    endcase
  endfunction : therm_degrees

  function automatic logic cmd_mapped(input logic [7:0] c);
    cmd_mapped = (c == `THERM_LIMIT_OFFSET) || (c == `LINK_CFG_OFFSET);
  endfunction : cmd_mapped

  // ------------------------------------------------------------
  // Byte transaction engine
  // ------------------------------------------------------------
  i2c_state_t state;
  i2c_state_t next_state;
  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [7:0] cmd;
  logic [7:0] next_cmd;
  logic cmd_ok;
  logic next_cmd_ok;
  logic is_read;
  logic next_is_read;
  logic ack_ok;
  logic next_ack_ok;
  logic ack_on;
  logic next_ack_on;
  logic next_sda_oe;
  logic wr_commit;
  logic [7:0] byte_in;
  logic [7:0] rd_byte;
  logic chk_allowed;

  logic [2:0] therm;
  logic [1:0] cfg_proto;
  logic [3:0] cfg_vboot;
  logic [1:0] cfg_bcast;

  assign byte_in = {shreg[6:0], sda_s};

  vboot_lookup u_write_check (
    .proto_sel(byte_in[`PROTO_MSB:`PROTO_LSB]),
    .vboot_code(byte_in[`VBOOT_MSB:`VBOOT_LSB]),
    .vid_code(),
    .allowed(chk_allowed)
  );

  always_comb begin
    if (cmd == `THERM_LIMIT_OFFSET) begin
      rd_byte = {5'h00, therm};
    end else begin
      rd_byte = {cfg_proto, cfg_vboot, cfg_bcast};
    end
  end

  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_cmd = cmd;
    next_cmd_ok = cmd_ok;
    next_is_read = is_read;
    next_ack_ok = ack_ok;
    next_ack_on = ack_on;
    next_sda_oe = sda_oe;
    wr_commit = 1'b0;
    if (bus_start) begin
      next_state = ST_ADDR;
      next_bit_cnt = 3'h0;
      next_sda_oe = 1'b0;
      next_ack_on = 1'b0;
    end else if (bus_stop) begin
      next_state = ST_IDLE;
      next_sda_oe = 1'b0;
      next_cmd_ok = 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          next_sda_oe = 1'b0;
        end
        ST_ADDR: if (scl_rise) begin
          next_shreg = byte_in;
          next_bit_cnt = bit_cnt + 3'h1;
          if (bit_cnt == 3'h7) begin
            // A read is only answered after a command byte was taken
            if (byte_in[7:1] == `I2C_DEV_ADDR && (!byte_in[0] || cmd_ok)) begin
              next_state = ST_ADDR_ACK;
              next_is_read = byte_in[0];
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: if (scl_fall) begin
          if (!ack_on) begin
            next_sda_oe = 1'b1;
            next_ack_on = 1'b1;
          end else begin
            next_ack_on = 1'b0;
            next_bit_cnt = 3'h0;
            if (is_read) begin
              next_state = ST_RDATA;
              next_shreg = rd_byte;
              next_sda_oe = !rd_byte[7];
            end else begin
              next_state = ST_CMD;
              next_sda_oe = 1'b0;
            end
          end
        end
        ST_CMD: if (scl_rise) begin
          next_shreg = byte_in;
          next_bit_cnt = bit_cnt + 3'h1;
          if (bit_cnt == 3'h7) begin
            next_cmd = byte_in;
            next_ack_ok = cmd_mapped(byte_in);
            next_state = ST_CMD_ACK;
          end
        end
        ST_CMD_ACK: if (scl_fall) begin
          if (!ack_on) begin
            next_sda_oe = ack_ok;
            next_ack_on = 1'b1;
          end else begin
            next_ack_on = 1'b0;
            next_sda_oe = 1'b0;
            next_bit_cnt = 3'h0;
            next_cmd_ok = ack_ok;
            next_state = ack_ok ? ST_WDATA : ST_IDLE;
          end
        end
        ST_WDATA: if (scl_rise) begin
          next_shreg = byte_in;
          next_bit_cnt = bit_cnt + 3'h1;
          if (bit_cnt == 3'h7) begin
            if (cmd == `LINK_CFG_OFFSET) begin
              next_ack_ok = chk_allowed;
            end else begin
              next_ack_ok = 1'b1;
            end
            next_state = ST_WDATA_ACK;
          end
        end
        ST_WDATA_ACK: if (scl_fall) begin
          if (!ack_on) begin
            next_sda_oe = ack_ok;
            next_ack_on = 1'b1;
            wr_commit = ack_ok;
          end else begin
            // Single byte only: further data is left unanswered
            next_ack_on = 1'b0;
            next_sda_oe = 1'b0;
            next_state = ST_IDLE;
          end
        end
        ST_RDATA: if (scl_fall) begin
          if (bit_cnt == 3'h7) begin
            next_sda_oe = 1'b0;
            next_state = ST_RDATA_ACK;
          end else begin
            next_shreg = {shreg[6:0], 1'b0};
            next_sda_oe = !shreg[6];
            next_bit_cnt = bit_cnt + 3'h1;
          end
        end
        ST_RDATA_ACK: if (scl_rise) begin
          next_state = ST_IDLE;
        end
        default: begin
          next_state = ST_IDLE;
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
      cmd <= 8'h00;
      cmd_ok <= 1'b0;
      is_read <= 1'b0;
      ack_ok <= 1'b0;
      ack_on <= 1'b0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      cmd <= next_cmd;
      cmd_ok <= next_cmd_ok;
      is_read <= next_is_read;
      ack_ok <= next_ack_ok;
      ack_on <= next_ack_on;
      sda_oe <= next_sda_oe;
      sda_out <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Registers and voltage-ID mirrors
  // ------------------------------------------------------------
  logic [2:0] next_therm;
  logic [1:0] next_cfg_proto;
  logic [3:0] next_cfg_vboot;
  logic [1:0] next_cfg_bcast;
  logic [1:0] next_eff_proto;
  logic [1:0] next_eff_bcast;
  logic [7:0] mirror_vid;

  vboot_lookup u_mirror (
    .proto_sel(next_eff_proto),
    .vboot_code(next_cfg_vboot),
    .vid_code(mirror_vid),
    .allowed()
  );

  always_comb begin
    next_therm = therm;
    next_cfg_proto = cfg_proto;
    next_cfg_vboot = cfg_vboot;
    next_cfg_bcast = cfg_bcast;
    if (wr_commit && cmd == `THERM_LIMIT_OFFSET) begin
      next_therm = shreg[`THERM_CODE_MSB:`THERM_CODE_LSB];
    end
    if (wr_commit && cmd == `LINK_CFG_OFFSET) begin
      next_cfg_proto = shreg[`PROTO_MSB:`PROTO_LSB];
      next_cfg_vboot = shreg[`VBOOT_MSB:`VBOOT_LSB];
      next_cfg_bcast = shreg[`BCAST_MSB:`BCAST_LSB];
    end
    // Live selections are frozen while the converter runs
    if (conv_enable) begin
      next_eff_proto = link_protocol_select;
      next_eff_bcast = broadcast_active;
    end else begin
      next_eff_proto = next_cfg_proto;
      next_eff_bcast = next_cfg_bcast;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      therm <= `THERM_CODE_RESET;
      cfg_proto <= `PROTO_RESET;
      cfg_vboot <= `VBOOT_RESET;
      cfg_bcast <= `BCAST_RESET;
      thermal_limit_code <= `THERM_CODE_RESET;
      thermal_limit_deg <= 8'h5F;
      vid_thermal_mirror <= 8'h00;
      link_protocol_select <= `PROTO_RESET;
      vid_link_ident <= `PROTO_ID_SEL1;
      vout_step_5mv <= 1'b1;
      vid_boot_code <= 8'h00;
      startup_target_vid <= 8'h00;
      startup_from_vid <= 1'b0;
      broadcast_active <= `BCAST_RESET;
      answer_bcast_0e <= 1'b1;
      answer_bcast_0f <= 1'b1;
      config_pending <= 1'b0;
    end else if (ce) begin
      therm <= next_therm;
      cfg_proto <= next_cfg_proto;
      cfg_vboot <= next_cfg_vboot;
      cfg_bcast <= next_cfg_bcast;
      thermal_limit_code <= next_therm;
      thermal_limit_deg <= therm_degrees(next_therm);
      vid_thermal_mirror <= {5'h00, next_therm};
      link_protocol_select <= next_eff_proto;
      vid_link_ident <= proto_ident(next_eff_proto);
      vout_step_5mv <= step_is_5mv(next_eff_proto);
      vid_boot_code <= mirror_vid;
      if (vout_ctrl_src == 2'h0 || vout_ctrl_src == 2'h1) begin
        startup_target_vid <= mirror_vid;
        startup_from_vid <= 1'b1;
      end else begin
        startup_target_vid <= 8'h00;
        startup_from_vid <= 1'b0;
      end
      broadcast_active <= next_eff_bcast;
      answer_bcast_0e <= next_eff_bcast[1];
      answer_bcast_0f <= next_eff_bcast[0];
      config_pending <= (next_eff_proto != next_cfg_proto) ||
                        (next_eff_bcast != next_cfg_bcast);
    end
  end

endmodule : vid_link_config_registers

`default_nettype wire

// >>> tb/link_cfg_sva.sv
// Port assertions for the link config registers
`timescale 1ns/1ps
`default_nettype none

module link_cfg_sva (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_oe,
  input wire logic conv_enable,
  input wire logic [1:0] vout_ctrl_src,
  input wire logic [2:0] thermal_limit_code,
  input wire logic [7:0] thermal_limit_deg,
  input wire logic [7:0] vid_thermal_mirror,
  input wire logic [1:0] link_protocol_select,
  input wire logic [7:0] vid_link_ident,
  input wire logic vout_step_5mv,
  input wire logic [7:0] vid_boot_code,
  input wire logic [7:0] startup_target_vid,
  input wire logic startup_from_vid,
  input wire logic [1:0] broadcast_active,
  input wire logic answer_bcast_0e,
  input wire logic answer_bcast_0f,
  input wire logic config_pending
);
  localparam logic [7:0] PID [4] = '{8'h04, 8'h07, 8'h09, 8'h0A};
  // Internal reset trails arst_n by two flops, so wait a few edges more
  logic [2:0] age;
  logic [2:0] next_age;
  always_comb begin
    next_age = (age == 3'h7) ? age : age + 3'h1;
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      age <= 3'h0;
    end else begin
      age <= next_age;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n || age != 3'h7);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  a_deg_map: assert property (
    $stable(thermal_limit_code) |-> thermal_limit_deg ==
    8'h5F + 8'h05 * {5'h00, thermal_limit_code})
    else $error("bad degrees");
  a_proto_id: assert property (
    $stable(link_protocol_select) |->
    vid_link_ident == PID[link_protocol_select]) else $error("bad id");
  a_step_size: assert property (
    $stable(link_protocol_select) |-> vout_step_5mv ==
    (link_protocol_select == 2'h1 || link_protocol_select == 2'h2))
    else $error("bad step");
  a_bcast_ans: assert property (
    $stable(broadcast_active) |->
    {answer_bcast_0e, answer_bcast_0f} == broadcast_active)
    else $error("bad broadcast answer");
  a_hold_running: assert property (
    conv_enable |=> $stable(link_protocol_select) &&
    $stable(broadcast_active)) else $error("applied while running");
  a_pend_clear: assert property (
    (ce && !conv_enable && !sda_oe) [*3] |-> !config_pending)
    else $error("pending while stopped");
  a_temp_mirror: assert property (
    vid_thermal_mirror == {5'h00, thermal_limit_code})
    else $error("bad thermal mirror");
  a_startup_src: assert property (
    $stable(vout_ctrl_src) && $stable(vid_boot_code) |->
    startup_from_vid == !vout_ctrl_src[1] &&
    startup_target_vid == (vout_ctrl_src[1] ? 8'h00 : vid_boot_code))
    else $error("bad start-up target");
  a_oe_scl_low: assert property (
    $changed(sda_oe) |-> !scl_in && !$past(scl_in, 2))
    else $error("data moved while clock high");
  c_ack: cover property ($rose(sda_oe));
  c_pending: cover property ($rose(config_pending));
  c_apply: cover property ($fell(conv_enable) && config_pending);
endmodule : link_cfg_sva

bind vid_link_config_registers link_cfg_sva u_sva (
  .core_clk, .arst_n, .ce, .scl_in, .sda_oe, .conv_enable, .vout_ctrl_src,
  .thermal_limit_code, .thermal_limit_deg, .vid_thermal_mirror,
  .link_protocol_select, .vid_link_ident, .vout_step_5mv, .vid_boot_code,
  .startup_target_vid, .startup_from_vid, .broadcast_active,
  .answer_bcast_0e, .answer_bcast_0f, .config_pending
);
`default_nettype wire

// >>> tb/i2c_host_model.sv
// Behavioural I2C host that reaches the link config registers
`timescale 1ns/1ps
`default_nettype none
`include "vid_link_cfg_defines.svh"

module i2c_host_model (
  input wire logic core_clk,
  input wire logic sda_oe,
  output logic scl,
  output logic sda_line
);
  localparam int HALF = 10;
  logic sda_m;
  // Open drain with pull-up: a released line reads high
  assign sda_line = sda_m & ~sda_oe;
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge core_clk);
  endtask : hold
  // Data moves 4 clocks after SCL falls so no edge looks like START
  task automatic start_cond();
    hold(4);
    sda_m = 1'b1;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    sda_m = 1'b0;
    hold(HALF);
    scl = 1'b0;
  endtask : start_cond
  task automatic stop_cond();
    hold(4);
    sda_m = 1'b0;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    sda_m = 1'b1;
    hold(HALF);
  endtask : stop_cond
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q,
                         output logic ack);
    logic [8:0] bits;
    bits = {d, 1'b1};
    for (int i = 8; i >= 0; i--) begin
      hold(4);
      sda_m = bits[i];
      hold(HALF);
      scl = 1'b1;
      hold(HALF / 2);
      if (i > 0) q[i - 1] = sda_line;
      else ack = ~sda_line;
      hold(HALF / 2);
      scl = 1'b0;
    end
  endtask : byte_io
  task automatic wr(input logic [7:0] cmd, input logic [7:0] data,
                    output logic ok);
    logic [7:0] q;
    logic a0, a1, a2;
    start_cond();
    byte_io({`I2C_DEV_ADDR, 1'b0}, q, a0);
    byte_io(cmd, q, a1);
    byte_io(data, q, a2);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask : wr
  task automatic rd(input logic [7:0] cmd, output logic [7:0] q,
                    output logic ok);
    logic a0, a1, a2, a3;
    start_cond();
    byte_io({`I2C_DEV_ADDR, 1'b0}, q, a0);
    byte_io(cmd, q, a1);
    start_cond();
    byte_io({`I2C_DEV_ADDR, 1'b1}, q, a2);
    byte_io(8'hFF, q, a3);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask : rd
endmodule : i2c_host_model
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the link config registers
`timescale 1ns/1ps
`default_nettype none
`include "vid_link_cfg_defines.svh"

module testbench;
  localparam logic [7:0] PID [4] = '{8'h04, 8'h07, 8'h09, 8'h0A};
  localparam logic [7:0] VID [16] = '{8'h00, 8'h65, 8'h6F, 8'h79,
    8'h83, 8'h8D, 8'h97, 8'hA1, 8'hAB, 8'hAF, 8'hC9, 8'hDD, 8'hFB,
    8'h6F, 8'h79, 8'h83};
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic conv_enable = 1'b0;
  logic ce = 1'b1;
  logic [1:0] vout_ctrl_src = 2'h0;
  logic scl, sda_line, sda_out, sda_oe, vout_step_5mv, startup_from_vid;
  logic answer_bcast_0e, answer_bcast_0f, config_pending;
  logic [2:0] thermal_limit_code;
  logic [1:0] link_protocol_select, broadcast_active;
  logic [7:0] thermal_limit_deg, vid_thermal_mirror, vid_link_ident;
  logic [7:0] vid_boot_code, startup_target_vid;
  int err_total = 0;
  int total_checks = 0;
  always #4 core_clk = ~core_clk;
  vid_link_config_registers DUT (
    .core_clk, .arst_n, .ce, .scl_in(scl), .sda_in(sda_line),
    .sda_out, .sda_oe, .conv_enable, .vout_ctrl_src, .thermal_limit_code,
    .thermal_limit_deg, .vid_thermal_mirror, .link_protocol_select,
    .vid_link_ident, .vout_step_5mv, .vid_boot_code, .startup_target_vid,
    .startup_from_vid, .broadcast_active, .answer_bcast_0e,
    .answer_bcast_0f, .config_pending);
  i2c_host_model host (.core_clk, .sda_oe, .scl, .sda_line);
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic t_reset();
    logic [7:0] q;
    logic ok;
    chk(vid_link_ident, 8'h07);
    chk({7'h00, sda_out}, 8'h00);
    chk(thermal_limit_deg, 8'h5F);
    host.rd(`LINK_CFG_OFFSET, q, ok);
    chk({7'h00, ok}, 8'h01);
    chk(q, 8'h43);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_therm();
    logic [7:0] q;
    logic ok;
    for (int c = 0; c < 8; c++) begin
      host.wr(`THERM_LIMIT_OFFSET, 8'hF8 | 8'(c), ok);
      chk({7'h00, ok}, 8'h01);
      chk(thermal_limit_deg, 8'(95 + 5 * c));
      chk(vid_thermal_mirror, 8'(c));
      chk({5'h00, thermal_limit_code}, 8'(c));
      host.rd(`THERM_LIMIT_OFFSET, q, ok);
      chk(q, 8'(c));
    end
    $display("t_therm done");
  endtask : t_therm
  task automatic t_proto();
    logic [7:0] q, d;
    logic ok;
    for (int s = 0; s < 4; s++) begin
      d = {2'(s), 4'h7, 2'(s)};
      host.wr(`LINK_CFG_OFFSET, d, ok);
      chk({7'h00, ok}, 8'h01);
      chk(vid_link_ident, PID[s]);
      chk({6'h00, answer_bcast_0e, answer_bcast_0f}, 8'(s));
      chk({6'h00, broadcast_active}, 8'(s));
      chk({7'h00, vout_step_5mv}, 8'(s == 1 || s == 2));
      chk(vid_boot_code, 8'hA1);
      host.rd(`LINK_CFG_OFFSET, q, ok);
      chk(q, d);
    end
    $display("t_proto done");
  endtask : t_proto
  task automatic t_check();
    logic [7:0] q, d, cfg;
    logic [1:0] s;
    logic [3:0] c;
    logic ok, good;
    cfg = 8'hDF;
    for (int i = 0; i < 32; i++) begin
      s = (i < 16) ? 2'h3 : 2'h1;
      c = 4'(i);
      d = {s, c, 2'h2};
      good = (c < 4'h7) ? (s == 2'h1) : (c > 4'hC) ? (s == 2'h3) : 1'b1;
      host.wr(`LINK_CFG_OFFSET, d, ok);
      chk({7'h00, ok}, {7'h00, good});
      if (good) cfg = d;
      chk(vid_boot_code, VID[cfg[5:2]]);
      chk({6'h00, link_protocol_select}, {6'h00, cfg[7:6]});
    end
    host.rd(`LINK_CFG_OFFSET, q, ok);
    chk(q, cfg);
    $display("t_check done");
  endtask : t_check
  // Stored value is 72h here: step 5 mV, boot 1.50 V, broadcast 0Eh only
  task automatic t_pending();
    logic [7:0] q;
    logic ok;
    conv_enable = 1'b1;
    host.wr(`LINK_CFG_OFFSET, 8'hA1, ok);
    chk(vid_boot_code, 8'hAB);
    chk({6'h00, link_protocol_select}, 8'h01);
    chk({6'h00, broadcast_active}, 8'h02);
    chk({7'h00, config_pending}, 8'h01);
    host.rd(`LINK_CFG_OFFSET, q, ok);
    chk(q, 8'hA1);
    // With the clock enable low the pending values must stay frozen
    ce = 1'b0;
    conv_enable = 1'b0;
    host.hold(4);
    chk({7'h00, config_pending}, 8'h01);
    chk({6'h00, link_protocol_select}, 8'h01);
    ce = 1'b1;
    host.hold(3);
    chk(vid_link_ident, 8'h09);
    chk({6'h00, broadcast_active}, 8'h01);
    chk({7'h00, config_pending}, 8'h00);
    for (int s = 0; s < 4; s++) begin
      vout_ctrl_src = 2'(s);
      host.hold(3);
      chk({7'h00, startup_from_vid}, 8'(s < 2));
      chk(startup_target_vid, (s < 2) ? 8'hAB : 8'h00);
    end
    host.wr(8'hC3, 8'h00, ok);
    chk({7'h00, ok}, 8'h00);
    $display("t_pending done");
  endtask : t_pending
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (10) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (6) @(negedge core_clk);
    t_reset();
    t_therm();
    t_proto();
    t_check();
    t_pending();
    wrap_up();
  end
  // The whole sequence needs about 50000 clocks
  initial begin
    repeat (90000) @(posedge core_clk);
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
